/* File: scb_array_model.sv */
// Far side: phase generator and comparator outputs
`timescale 1ns/1ps
`default_nettype none
module scb_array_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] cmpIn,
  output logic phaseOneExt,
  output logic phaseTwoExt,
  output logic lateHalf,
  output logic [3:0] compRaw
);
  logic [2:0] phaseCnt_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) phaseCnt_reg <= 3'h0;
    else phaseCnt_reg <= phaseCnt_reg + 3'h1;
  end
  // Idle counts 0 and 4 keep the phases from overlapping
  assign phaseOneExt = !phaseCnt_reg[2] && phaseCnt_reg != 3'h0;
  assign phaseTwoExt = phaseCnt_reg[2] && phaseCnt_reg != 3'h4;
  assign lateHalf = phaseCnt_reg[1] && phaseCnt_reg[0];
  assign compRaw = cmpIn;
endmodule : scb_array_model
`default_nettype wire

/* File: scb_pkg.sv */
// Constants and types for the type-A switched-capacitor block control
// Function
// [RULE1] B capacitor code closes that many units
// [RULE2] C capacitor code closes that many units
// [RULE3] Column bus off leaves output high impedance
// [RULE4] Unswapped: column bus only late phase two
// [RULE5] Swapped: column bus driven continuously
// [RULE6] Comparator bus enable gates latched result
// [RULE7] Undriven comparator bus reads low
// [RULE8] Comparator latched on rising internal phase one
// [RULE9] Offset null shorts and grounds in phase one
// [RULE10] Reference code picks ground, high, low
// [RULE11] Code three follows comparator for reference
// [RULE12] Feedback switch gated by offset null
// [RULE13] Output ground switch closes in phase one
// [RULE14] B input code picks one of four
// [RULE15] Power code zero is off, reset off
// [RULE16] Control 2 at 82h, 8Ah, 96h, 9Eh
// [RULE17] Phase swap exchanges internal phases
// [RULE18] Gating registered, changes only on clock
package scb_pkg;
  localparam int NUM_BLOCKS = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // Register indices, byte address is four times the index
  localparam logic [7:0] CTRL1_IDX [NUM_BLOCKS] = '{8'h81, 8'h89, 8'h95, 8'h9d};
  localparam logic [7:0] CTRL2_IDX [NUM_BLOCKS] = '{8'h82, 8'h8a, 8'h96, 8'h9e};
  localparam logic [7:0] CTRL3_IDX [NUM_BLOCKS] = '{8'h83, 8'h88, 8'h97, 8'h9f};
  localparam logic [7:0] PHASE_IDX [NUM_BLOCKS] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3};
  localparam logic [7:0] STATUS_IDX = 8'ha4;
  // Register slot numbers inside one block
  localparam logic [1:0] SLOT_PHASE = 2'h0;
  localparam logic [1:0] SLOT_CTRL1 = 2'h1;
  localparam logic [1:0] SLOT_CTRL2 = 2'h2;
  localparam logic [1:0] SLOT_CTRL3 = 2'h3;
  // Field positions
  localparam int CAP_MSB = 4;
  localparam int BIT_PHASE_SWAP = 6;
  localparam int BIT_COLUMN_BUS = 7;
  localparam int BIT_COMP_BUS = 6;
  localparam int BIT_OFFSET_NULL = 5;
  localparam int REF_MSB = 7;
  localparam int REF_LSB = 6;
  localparam int BIT_FEEDBACK_SW = 5;
  localparam int BIT_GROUND_SW = 4;
  localparam int BSEL_MSB = 3;
  localparam int BSEL_LSB = 2;
  localparam int PWR_MSB = 1;
  localparam int PWR_LSB = 0;
  localparam int STATUS_POWER_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {REF_GROUND, REF_HIGH, REF_LOW} scb_ref_type;

  typedef struct packed {
    logic [30:0] bCapUnits;
    logic [30:0] cCapUnits;
    logic columnBusConnect;
    logic compBusLevel;
    logic offsetShort;
    logic branchGround;
    logic branchToSum;
    logic feedbackClosed;
    logic outputGroundClosed;
    scb_ref_type refSel;
    logic [3:0] bSourceSel;
    logic [1:0] powerLevel;
    logic powerOn;
  } scb_gate_type;
endpackage : scb_pkg

/* File: scb_switch_control.sv */
// Register file, AXI4-Lite slave and switch gating for four type-A blocks
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scb_switch_control
(
  input wire logic clk,
  input wire logic rst_n,
  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  input wire logic [scb_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [scb_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // ----------------------------------------
  // Analog array side
  // ----------------------------------------
  input wire logic phaseOneExt,
  input wire logic phaseTwoExt,
  input wire logic lateHalf,
  input wire logic [scb_pkg::NUM_BLOCKS-1:0] compRaw,
  output scb_pkg::scb_gate_type [scb_pkg::NUM_BLOCKS-1:0] gates
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Returns {hit, block, slot}
  function automatic logic [4:0] decodeIdx(input logic [7:0] idx);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < scb_pkg::NUM_BLOCKS; i++)
    begin
      if (idx == scb_pkg::PHASE_IDX[i])
        res = {1'b1, 2'(i), scb_pkg::SLOT_PHASE};
      if (idx == scb_pkg::CTRL1_IDX[i])
        res = {1'b1, 2'(i), scb_pkg::SLOT_CTRL1};
      if (idx == scb_pkg::CTRL2_IDX[i])
        res = {1'b1, 2'(i), scb_pkg::SLOT_CTRL2}; // RULE16
      if (idx == scb_pkg::CTRL3_IDX[i])
        res = {1'b1, 2'(i), scb_pkg::SLOT_CTRL3};
    end
    return res;
  endfunction : decodeIdx

  // Plain binary count turned into a row of closed unit capacitors
  function automatic logic [30:0] unitsClosed(input logic [4:0] code);
    logic [30:0] res;
    res = 31'h0;
    for (int i = 0; i < 31; i++)
      res[i] = (5'(i) < code);
    return res;
  endfunction : unitsClosed

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] ctrlReg [scb_pkg::NUM_BLOCKS][4];
  logic awHeldReg;
  logic wHeldReg;
  logic [7:0] awIdxReg;
  logic [7:0] wByteReg;
  logic wLaneReg;
  logic bvalidReg;
  logic [1:0] brespReg;
  logic rvalidReg;
  logic [31:0] rdataReg;
  logic [1:0] rrespReg;
  logic [scb_pkg::NUM_BLOCKS-1:0] compLatchReg;
  logic [scb_pkg::NUM_BLOCKS-1:0] phaseOnePrevReg;
  scb_pkg::scb_gate_type [scb_pkg::NUM_BLOCKS-1:0] gateReg;
  scb_pkg::scb_gate_type [scb_pkg::NUM_BLOCKS-1:0] gateNext;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Bank select sits above the index and is ignored, so all four banks alias
  wire logic awTake = awvalid & awready;
  wire logic wTake = wvalid & wready;
  wire logic doWrite = awHeldReg & wHeldReg;
  wire logic [4:0] wrDec = decodeIdx(awIdxReg);
  wire logic wrHit = wrDec[4];
  wire logic [1:0] wrBlock = wrDec[3:2];
  wire logic [1:0] wrSlot = wrDec[1:0];

  assign awready = ~awHeldReg & ~bvalidReg;
  assign wready = ~wHeldReg & ~bvalidReg;
  assign bvalid = bvalidReg;
  assign bresp = brespReg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeldReg <= 1'b0;
      wHeldReg <= 1'b0;
      awIdxReg <= 8'h00;
      wByteReg <= 8'h00;
      wLaneReg <= 1'b0;
    end
    else
    begin
      if (awTake)
      begin
        awHeldReg <= 1'b1;
        awIdxReg <= awaddr[scb_pkg::IDX_MSB:scb_pkg::IDX_LSB];
      end
      else if (doWrite)
        awHeldReg <= 1'b0;
      if (wTake)
      begin
        wHeldReg <= 1'b1;
        wByteReg <= wdata[7:0];
        wLaneReg <= wstrb[0];
      end
      else if (doWrite)
        wHeldReg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalidReg <= 1'b0;
      brespReg <= scb_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalidReg <= 1'b1;
      brespReg <= wrHit ? scb_pkg::RESP_OKAY : scb_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalidReg <= 1'b0;
  end

  // Reset clears every field, so each block comes up powered off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int b = 0; b < scb_pkg::NUM_BLOCKS; b++)
        for (int s = 0; s < 4; s++)
          ctrlReg[b][s] <= scb_pkg::RESET_VALUE; // RULE15
    end
    else if (doWrite && wrHit && wLaneReg)
      ctrlReg[wrBlock][wrSlot] <= wByteReg;
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  wire logic arTake = arvalid & arready;
  wire logic [7:0] rdIdx = araddr[scb_pkg::IDX_MSB:scb_pkg::IDX_LSB];
  wire logic [4:0] rdDec = decodeIdx(rdIdx);
  wire logic rdStatus = (rdIdx == scb_pkg::STATUS_IDX);
  logic [3:0] powerOnVec;
  wire logic [7:0] statusByte = {powerOnVec, compLatchReg};
  wire logic [7:0] rdByte = rdStatus ? statusByte
                          : (rdDec[4] ? ctrlReg[rdDec[3:2]][rdDec[1:0]] : 8'h00);

  assign arready = ~rvalidReg;
  assign rvalid = rvalidReg;
  assign rdata = rdataReg;
  assign rresp = rrespReg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalidReg <= 1'b0;
      rdataReg <= 32'h0;
      rrespReg <= scb_pkg::RESP_OKAY;
    end
    else if (arTake)
    begin
      rvalidReg <= 1'b1;
      rdataReg <= {24'h0, rdByte};
      rrespReg <= (rdDec[4] | rdStatus) ? scb_pkg::RESP_OKAY : scb_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalidReg <= 1'b0;
  end

  // ----------------------------------------
  // Per-block switch gating
  // ----------------------------------------
  for (genvar g = 0; g < scb_pkg::NUM_BLOCKS; g++)
  begin : gen_block
    wire logic [7:0] cr0 = ctrlReg[g][scb_pkg::SLOT_PHASE];
    wire logic [7:0] cr1 = ctrlReg[g][scb_pkg::SLOT_CTRL1];
    wire logic [7:0] cr2 = ctrlReg[g][scb_pkg::SLOT_CTRL2];
    wire logic [7:0] cr3 = ctrlReg[g][scb_pkg::SLOT_CTRL3];
    wire logic swap = cr0[scb_pkg::BIT_PHASE_SWAP];
    wire logic phaseOne = swap ? phaseTwoExt : phaseOneExt; // RULE17
    wire logic phaseTwo = swap ? phaseOneExt : phaseTwoExt; // RULE17
    wire logic colEn = cr2[scb_pkg::BIT_COLUMN_BUS];
    wire logic cmpEn = cr2[scb_pkg::BIT_COMP_BUS];
    wire logic nullEn = cr2[scb_pkg::BIT_OFFSET_NULL];
    wire logic [1:0] refCode = cr3[scb_pkg::REF_MSB:scb_pkg::REF_LSB];
    wire logic [1:0] bCode = cr3[scb_pkg::BSEL_MSB:scb_pkg::BSEL_LSB];
    wire logic [1:0] pwr = cr3[scb_pkg::PWR_MSB:scb_pkg::PWR_LSB];
    wire logic phaseOneRise = phaseOne & ~phaseOnePrevReg[g];
    scb_pkg::scb_ref_type refNext;

    always_comb
    begin
      case (refCode) // RULE10
        2'h0: refNext = scb_pkg::REF_GROUND;
        2'h1: refNext = scb_pkg::REF_HIGH;
        2'h2: refNext = scb_pkg::REF_LOW;
        2'h3: refNext = compLatchReg[g] ? scb_pkg::REF_HIGH : scb_pkg::REF_LOW; // RULE11
        default: refNext = scb_pkg::REF_GROUND;
      endcase
    end

    // Column bus stays high impedance unless enabled
    assign gateNext[g].columnBusConnect = colEn & (swap | (phaseTwo & lateHalf)); // RULE3 RULE4 RULE5
    // Not driving puts a low on the shared wired-OR bus
    assign gateNext[g].compBusLevel = cmpEn & compLatchReg[g]; // RULE6 RULE7
    assign gateNext[g].bCapUnits = unitsClosed(cr1[scb_pkg::CAP_MSB:0]); // RULE1
    assign gateNext[g].cCapUnits = unitsClosed(cr2[scb_pkg::CAP_MSB:0]); // RULE2
    assign gateNext[g].offsetShort = nullEn & phaseOne; // RULE9
    assign gateNext[g].branchGround = nullEn & phaseOne; // RULE9
    assign gateNext[g].branchToSum = ~nullEn | phaseTwo; // RULE9
    assign gateNext[g].feedbackClosed = cr3[scb_pkg::BIT_FEEDBACK_SW] & (~nullEn | phaseTwo); // RULE12
    assign gateNext[g].outputGroundClosed = cr3[scb_pkg::BIT_GROUND_SW] & phaseOne; // RULE13
    assign gateNext[g].refSel = refNext;
    // Code to source wiring differs per block and lives in the analog array
    assign gateNext[g].bSourceSel = 4'h1 << bCode; // RULE14
    assign gateNext[g].powerLevel = pwr; // RULE15
    assign gateNext[g].powerOn = |pwr; // RULE15
    assign powerOnVec[g] = gateReg[g].powerOn;

    // Latch holds through phase two so the bus sees a stable value
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        phaseOnePrevReg[g] <= 1'b0;
        compLatchReg[g] <= 1'b0;
      end
      else
      begin
        phaseOnePrevReg[g] <= phaseOne;
        if (phaseOneRise)
          compLatchReg[g] <= compRaw[g]; // RULE8
      end
    end
  end

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  // One cycle of lag traded for glitch-free switch drives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gateReg <= '0;
    else
      gateReg <= gateNext; // RULE18
  end

  assign gates = gateReg;

endmodule : scb_switch_control
`default_nettype wire

/* File: scb_switch_control_sva.sv */
// Concurrent checks on the switch control block ports
`timescale 1ns/1ps
`default_nettype none
module scb_switch_control_sva
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic phaseOneExt,
  input wire logic phaseTwoExt,
  input wire scb_pkg::scb_gate_type [scb_pkg::NUM_BLOCKS-1:0] gates
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_short_ground: assert property (gates[0].offsetShort == gates[0].branchGround)
    else $error("short and ground differ");
  chk_short_sum: assert property (gates[0].offsetShort |-> !gates[0].branchToSum)
    else $error("branch joined during short");
  chk_fb_apart: assert property (!(gates[0].feedbackClosed && gates[0].offsetShort))
    else $error("feedback closed during short");
  chk_gnd_phase: assert property (gates[0].outputGroundClosed |-> $past(phaseOneExt || phaseTwoExt))
    else $error("ground switch outside a phase");
  chk_b_branch_cap_size_thermo: assert property (((gates[0].bCapUnits + 31'h1) & gates[0].bCapUnits) == 31'h0)
    else $error("b units not contiguous");
  chk_c_branch_cap_size_thermo: assert property (((gates[0].cCapUnits + 31'h1) & gates[0].cCapUnits) == 31'h0)
    else $error("c units not contiguous");
  chk_power_flag: assert property (gates[0].powerOn == (gates[0].powerLevel != 2'h0))
    else $error("power flag wrong");
  chk_bsel_hot: assert property ($onehot0(gates[0].bSourceSel))
    else $error("b source not one-hot");
  chk_ref_legal: assert property (gates[0].refSel != 2'h3)
    else $error("reference code illegal");
  chk_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule : scb_switch_control_sva
bind scb_switch_control scb_switch_control_sva u_scb_switch_control_sva (.clk, .rst_n, .arvalid,
  .arready, .rvalid, .rready, .rdata, .bvalid, .bready, .bresp, .phaseOneExt, .phaseTwoExt, .gates);
`default_nettype wire

/* File: scb_switch_control_test.sv */
// Self-checking bench for the switch control block
`timescale 1ns/1ps
`default_nettype none
module scb_switch_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic [3:0] cmpIn = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, phaseOneExt, phaseTwoExt, lateHalf;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] compRaw;
  scb_pkg::scb_gate_type [3:0] gates;
  int n_mismatch = 0, total_checks = 0, cyc = 0, ansDelay = 0;
  always #2.5 clk = ~clk;
  scb_switch_control u_scb_switch_control (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .phaseOneExt, .phaseTwoExt, .lateHalf, .compRaw, .gates);
  scb_array_model u_scb_array_model (.clk, .rst_n, .cmpIn, .phaseOneExt, .phaseTwoExt, .lateHalf, .compRaw);
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int hold;
    hold = ansDelay;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (hold == 0);
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      // A late bready makes the slave hold its answer
      if (bvalid && !bready)
      begin
        hold--;
        if (hold == 0) bready <= 1'b1;
      end
    end
    while (!(bvalid && bready));
    chk(bresp, er);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    int hold;
    hold = ansDelay;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (hold == 0);
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready)
      begin
        hold--;
        if (hold == 0) rready <= 1'b1;
      end
    end
    while (!(rvalid && rready));
    chk(rdata, {24'h0, e});
    chk(rresp, er);
    rready <= 1'b0;
  endtask : rd
  task automatic t_regs;
    for (int g = 0; g < 4; g++)
    begin
      rd(ad(scb_pkg::CTRL2_IDX[g]), 8'h00, 2'h0);
      rd(ad(scb_pkg::CTRL3_IDX[g]), 8'h00, 2'h0);
      // Bank alias bit set on the write, clear on the read
      wr({2'h1, scb_pkg::CTRL2_IDX[g], 2'h0}, 8'h11 + 8'(g), 2'h0);
      rd(ad(scb_pkg::CTRL2_IDX[g]), 8'h11 + 8'(g), 2'h0);
      chk({1'b0, gates[g].cCapUnits}, (32'h1 << (17 + g)) - 32'h1);
      wr(ad(scb_pkg::CTRL2_IDX[g]), 8'h00, 2'h0);
    end
    rd(ad(8'h10), 8'h00, scb_pkg::RESP_SLVERR);
    wr(ad(8'h10), 8'h5a, scb_pkg::RESP_SLVERR);
    $display("register test done");
  endtask : t_regs
  task automatic t_stall;
    ansDelay = 3;
    wr(ad(scb_pkg::CTRL2_IDX[1]), 8'h1f, 2'h0);
    rd(ad(scb_pkg::CTRL2_IDX[1]), 8'h1f, 2'h0);
    ansDelay = 0;
    chk({1'b0, gates[1].cCapUnits}, 32'h7fffffff);
    $display("stall test done");
  endtask : t_stall
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(gates[0].powerOn, 1'b0);
    rst_n <= 1'b1;
    rd(ad(scb_pkg::CTRL3_IDX[0]), 8'h00, 2'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_caps;
    logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h0d, 5'h1f};
    foreach (codes[k])
    begin
      wr(ad(scb_pkg::CTRL1_IDX[0]), {3'h0, codes[k]}, 2'h0);
      wr(ad(scb_pkg::CTRL2_IDX[0]), {3'h0, codes[k]}, 2'h0);
      repeat (2) @(posedge clk);
      chk({1'b0, gates[0].bCapUnits}, (32'h1 << codes[k]) - 32'h1);
      chk({1'b0, gates[0].cCapUnits}, (32'h1 << codes[k]) - 32'h1);
    end
    $display("capacitor test done");
  endtask : t_caps
  task automatic t_ctrl3;
    for (int i = 0; i < 4; i++)
    begin
      wr(ad(scb_pkg::CTRL3_IDX[0]), {i[1:0], 2'h0, i[1:0], i[1:0]}, 2'h0);
      repeat (2) @(posedge clk);
      if (i < 3) chk(gates[0].refSel, i);
      else chk(gates[0].refSel, scb_pkg::REF_LOW);
      chk(gates[0].bSourceSel, 32'h1 << i);
      chk(gates[0].powerLevel, i);
      chk(gates[0].powerOn, i != 0);
    end
    $display("control 3 test done");
  endtask : t_ctrl3
  task automatic t_phase(input logic s, input logic [7:0] c2, input logic [7:0] c3);
    logic i1, i2, lt;
    wr(ad(scb_pkg::PHASE_IDX[0]), {1'b0, s, 6'h00}, 2'h0);
    wr(ad(scb_pkg::CTRL2_IDX[0]), c2, 2'h0);
    wr(ad(scb_pkg::CTRL3_IDX[0]), c3, 2'h0);
    repeat (2) @(posedge clk);
    for (int k = 0; k < 24; k++)
    begin
      @(posedge clk);
      i1 = s ? phaseTwoExt : phaseOneExt;
      i2 = s ? phaseOneExt : phaseTwoExt;
      lt = lateHalf;
      #1;
      chk(gates[0].columnBusConnect, c2[7] & (s | (i2 & lt)));
      chk(gates[0].offsetShort, c2[5] & i1);
      chk(gates[0].branchToSum, !c2[5] | i2);
      chk(gates[0].feedbackClosed, c3[5] & (!c2[5] | i2));
      chk(gates[0].outputGroundClosed, c3[4] & i1);
    end
    $display("phase test done");
  endtask : t_phase
  task automatic t_comp;
    wr(ad(scb_pkg::CTRL2_IDX[0]), 8'h40, 2'h0);
    wr(ad(scb_pkg::CTRL3_IDX[0]), 8'hc0, 2'h0);
    cmpIn <= 4'h1;
    repeat (20) @(posedge clk);
    chk(gates[0].compBusLevel, 1'b1);
    chk(gates[0].refSel, scb_pkg::REF_HIGH);
    // A change inside phase two must not reach the bus before phase one
    while (!phaseTwoExt) @(posedge clk);
    cmpIn <= 4'h0;
    repeat (2) @(posedge clk);
    chk(gates[0].compBusLevel, 1'b1);
    repeat (20) @(posedge clk);
    chk(gates[0].compBusLevel, 1'b0);
    chk(gates[0].refSel, scb_pkg::REF_LOW);
    wr(ad(scb_pkg::CTRL2_IDX[0]), 8'h00, 2'h0);
    cmpIn <= 4'h1;
    repeat (20) @(posedge clk);
    chk(gates[0].compBusLevel, 1'b0);
    $display("comparator test done");
  endtask : t_comp
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    chk(gates[0].powerOn, 1'b0);
    rst_n <= 1'b1;
    t_regs;
    t_stall;
    t_caps;
    t_ctrl3;
    t_reset;
    t_phase(1'b0, 8'h80, 8'h30);
    t_phase(1'b1, 8'h80, 8'h30);
    t_phase(1'b0, 8'h20, 8'h30);
    t_phase(1'b1, 8'ha0, 8'h10);
    t_phase(1'b0, 8'h00, 8'h20);
    t_comp;
    give_verdict;
  end
endmodule : scb_switch_control_test
`default_nettype wire
